// File: hw/datapath_config_top.sv
// Datapath configuration register with serial port and input assembly
//
// Function
// - Sixteen-bit register at serial address 0x01
// - Bit 14 holds NCO phase accumulator cleared
// - Bit 13 enables PN code synchronization
// - Bit 12 selects pulse or PN sync
// - Bit 11 enables pulse synchronization
// - Bit 9 enables inverse sinc, else bypass
// - Bit 8 drives data clock pin, default on
// - Bits 7:6 select interpolation 1x to 8x
// - Bit 5 clear means two's complement input
// - Dual port: I on first, Q second
// - Single port: alternating I/Q on first port
// - Bit 3 disables Q path after modulation
// - Bit 2 inverts gate pin I/Q polarity
// - Q-first clear pairs I with following Q
// - Q-first set pairs I with previous Q
// - Bit 0 halves NCO modulator input
`timescale 1ns/100ps
`include "datapath_params.svh"
module datapath_config_top import datapath_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic SPI_CS_N,
	input wire logic SPI_SCLK,
	input wire logic SPI_SDI,
	output logic SPI_SDO,
	output logic SPI_SDO_OE,
	input wire logic [`DP_SAMPLE_W-1:0] FIRST_DATA_PORT,
	input wire logic [`DP_SAMPLE_W-1:0] SECOND_DATA_PORT,
	input wire logic TRANSMIT_GATE_PIN,
	output logic DATA_CLOCK_OUT_PIN,
	output logic DATA_CLOCK_OUT_OE,
	output sample_pair_s SAMPLE_PAIR,
	output logic SAMPLE_VALID,
	output logic NCO_PHASE_CLEAR,
	output logic PN_SYNC_ENABLE,
	output logic SYNC_MODE_PN,
	output logic PULSE_SYNC_ENABLE,
	output logic INV_SINC_ENABLE,
	output interp_e INTERP_FACTOR,
	output logic NCO_HALF_GAIN
);

	localparam int SW = `DP_SAMPLE_W;
	localparam int SYNC_W = 2 * SW + 4;

	// Synchronised pins
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic sdi_s;
	logic gate_s;
	logic [SW-1:0] p1_s;
	logic [SW-1:0] p2_s;

	assign pins_raw = {SPI_CS_N, SPI_SCLK, SPI_SDI, TRANSMIT_GATE_PIN,
		FIRST_DATA_PORT, SECOND_DATA_PORT};

	sync2 #(
		.W(SYNC_W),
		.INIT({1'b1, {(SYNC_W - 1){1'b0}}})
	) u_sync (
		.clk(REF_CLK),
		.rst(RST),
		.d(pins_raw),
		.q(pins_s)
	);

	assign cs_n_s = pins_s[SYNC_W-1];
	assign sclk_s = pins_s[SYNC_W-2];
	assign sdi_s = pins_s[SYNC_W-3];
	assign gate_s = pins_s[SYNC_W-4];
	assign p1_s = pins_s[2*SW-1:SW];
	assign p2_s = pins_s[SW-1:0];

	// Serial port state
	spi_state_e state_reg;
	spi_state_e state_next;
	logic sclk_d_reg;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [15:0] sin_reg;
	logic [15:0] sin_next;
	logic [15:0] sout_reg;
	logic [15:0] sout_next;
	logic rd_reg;
	logic rd_next;
	logic sdo_next;
	logic oe_next;
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic hit_reg;
	logic hit_next;

	// Edge and decode wires
	logic sclk_rise;
	logic sclk_fall;
	logic [7:0] instr_byte;
	logic instr_rd;
	logic instr_hit;
	logic [15:0] data_word;
	logic [15:0] read_word;

	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;
	assign instr_byte = {sin_reg[6:0], sdi_s};
	assign instr_rd = instr_byte[`DP_INSTR_RD];
	assign instr_hit = (instr_byte[`DP_ADDR_MSB:0] == `DP_CFG_ADDR);
	assign data_word = {sin_reg[14:0], sdi_s};
	// Unmapped addresses read as zero; reserved bits read zero
	assign read_word = instr_hit ? (cfg_reg & `DP_CFG_WMASK) : 16'h0000;

	logic instr_done;
	logic data_done;
	logic cfg_write;
	assign instr_done = sclk_rise && (cnt_reg == `DP_INSTR_LAST);
	assign data_done = sclk_rise && (cnt_reg == `DP_DATA_LAST);
	// Only a write frame that addressed this register lands
	assign cfg_write = data_done && !rd_reg && hit_reg;

	// Frame decoder: instruction byte, then one data word
	always_comb begin
		state_next = state_reg;
		hit_next = hit_reg;
		cnt_next = cnt_reg;
		sin_next = sin_reg;
		sout_next = sout_reg;
		rd_next = rd_reg;
		sdo_next = SPI_SDO;
		oe_next = SPI_SDO_OE;
		cfg_next = cfg_reg;
		// Chip select high aborts the frame
		if (cs_n_s) begin
			state_next = ST_IDLE;
			cnt_next = 4'h0;
			rd_next = 1'b0;
			hit_next = 1'b0;
			sdo_next = 1'b0;
			oe_next = 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					state_next = ST_INSTR;
					cnt_next = 4'h0;
				end
				ST_INSTR: begin
					if (sclk_rise) begin
						sin_next = data_word;
						cnt_next = cnt_reg + 4'h1;
						// Eighth instruction bit latches direction and match
						if (instr_done) begin
							state_next = ST_DATA;
							cnt_next = 4'h0;
							rd_next = instr_rd;
							hit_next = instr_hit;
							oe_next = instr_rd;
							sout_next = read_word;
						end
					end
				end
				// Sixteen data bits, read data leaves on falls
				ST_DATA: begin
					if (sclk_fall && rd_reg) begin
						sdo_next = sout_reg[15];
						sout_next = {sout_reg[14:0], 1'b0};
					end
					if (sclk_rise) begin
						sin_next = data_word;
						cnt_next = cnt_reg + 4'h1;
						if (data_done) begin
							state_next = ST_DONE;
							if (cfg_write) begin
								cfg_next = data_word & `DP_CFG_WMASK;
							end
						end
					end
				end
				// Extra clocks ignored until chip select rises
				ST_DONE: begin
					if (sclk_fall) begin
						sdo_next = 1'b0;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// Frame sequencing
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			sclk_d_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			sclk_d_reg <= sclk_s;
			cnt_reg <= cnt_next;
		end
	end

	// Serial input shifter
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sin_reg <= 16'h0000;
		end else begin
			sin_reg <= sin_next;
		end
	end

	// Read data shifter
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sout_reg <= 16'h0000;
		end else begin
			sout_reg <= sout_next;
		end
	end

	// Direction and address match of the current frame
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rd_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else begin
			rd_reg <= rd_next;
			hit_reg <= hit_next;
		end
	end

	// Read data pin
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			SPI_SDO <= 1'b0;
			SPI_SDO_OE <= 1'b0;
		end else begin
			SPI_SDO <= sdo_next;
			SPI_SDO_OE <= oe_next;
		end
	end

	// Configuration store
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cfg_reg <= `DP_CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// Configuration fields driven straight from the register
	assign NCO_PHASE_CLEAR = cfg_reg[`DP_B_PHASE_CLR];
	assign PN_SYNC_ENABLE = cfg_reg[`DP_B_PN_EN];
	assign SYNC_MODE_PN = cfg_reg[`DP_B_SYNC_SEL];
	assign PULSE_SYNC_ENABLE = cfg_reg[`DP_B_PULSE_EN];
	assign INV_SINC_ENABLE = cfg_reg[`DP_B_INV_SINC];
	assign DATA_CLOCK_OUT_OE = cfg_reg[`DP_B_DCLK_OE];
	assign INTERP_FACTOR = interp_e'(cfg_reg[`DP_B_INTERP_HI:`DP_B_INTERP_LO]);
	assign NCO_HALF_GAIN = cfg_reg[`DP_B_HALF_GAIN];

	// Data clock pin toggles while enabled, held low otherwise
	logic dclk_next;
	assign dclk_next = cfg_reg[`DP_B_DCLK_OE] & ~DATA_CLOCK_OUT_PIN;

	// Input word conversion and I/Q identification
	logic fmt_offset;
	logic single_mode;
	logic real_mode;
	logic q_first;
	logic word_is_i;
	logic [SW-1:0] w1;
	logic [SW-1:0] w2;

	assign fmt_offset = cfg_reg[`DP_B_FORMAT];
	assign single_mode = cfg_reg[`DP_B_SINGLE];
	assign real_mode = cfg_reg[`DP_B_REAL];
	assign q_first = cfg_reg[`DP_B_Q_FIRST];
	// Two's complement passes through; set format bit flips the sign bit
	assign w1 = fmt_offset ? {~p1_s[SW-1], p1_s[SW-2:0]} : p1_s;
	assign w2 = fmt_offset ? {~p2_s[SW-1], p2_s[SW-2:0]} : p2_s;
	assign word_is_i = gate_s ^ cfg_reg[`DP_B_IQ_INV];

	// Pair assembly
	logic [SW-1:0] hold_i_reg;
	logic [SW-1:0] hold_q_reg;
	logic [SW-1:0] hold_i_next;
	logic [SW-1:0] hold_q_next;
	logic pair_fire;
	logic [SW-1:0] pair_i;
	logic [SW-1:0] pair_q;
	logic [SW-1:0] out_q;
	sample_pair_s pair_next;

	assign hold_i_next = (single_mode && word_is_i) ? w1 : hold_i_reg;
	assign hold_q_next = (single_mode && !word_is_i) ? w1 : hold_q_reg;
	// Q-first fires on an I word with the earlier Q, else on Q with held I
	assign pair_fire = !single_mode || (q_first ? word_is_i : !word_is_i);
	assign pair_i = !single_mode ? w1 : (q_first ? w1 : hold_i_reg);
	assign pair_q = !single_mode ? w2 : (q_first ? hold_q_reg : w1);
	assign out_q = real_mode ? {SW{1'b0}} : pair_q;
	assign pair_next = '{i: pair_i, q: out_q};

	// Data clock pin
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			DATA_CLOCK_OUT_PIN <= 1'b0;
		end else begin
			DATA_CLOCK_OUT_PIN <= dclk_next;
		end
	end

	// Held I word for single-port pairing
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			hold_i_reg <= {SW{1'b0}};
		end else begin
			hold_i_reg <= hold_i_next;
		end
	end

	// Held Q word for single-port pairing
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			hold_q_reg <= {SW{1'b0}};
		end else begin
			hold_q_reg <= hold_q_next;
		end
	end

	// Assembled pair and its strobe
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			SAMPLE_PAIR <= '0;
			SAMPLE_VALID <= 1'b0;
		end else begin
			SAMPLE_VALID <= pair_fire;
			if (pair_fire) begin
				SAMPLE_PAIR <= pair_next;
			end
		end
	end

endmodule : datapath_config_top

// File: hw/datapath_params.svh
// Constants for the datapath configuration register and its serial port
`ifndef DATAPATH_PARAMS_SVH
`define DATAPATH_PARAMS_SVH

`define DP_SAMPLE_W 16
`define DP_CFG_ADDR 5'h01
`define DP_CFG_RESET 16'h0100
`define DP_CFG_WMASK 16'h7BFF
`define DP_INSTR_RD 7
`define DP_ADDR_MSB 4
`define DP_INSTR_LAST 4'h7
`define DP_DATA_LAST 4'hF

`define DP_B_PHASE_CLR 14
`define DP_B_PN_EN 13
`define DP_B_SYNC_SEL 12
`define DP_B_PULSE_EN 11
`define DP_B_INV_SINC 9
`define DP_B_DCLK_OE 8
`define DP_B_INTERP_HI 7
`define DP_B_INTERP_LO 6
`define DP_B_FORMAT 5
`define DP_B_SINGLE 4
`define DP_B_REAL 3
`define DP_B_IQ_INV 2
`define DP_B_Q_FIRST 1
`define DP_B_HALF_GAIN 0

`endif

// File: hw/datapath_pkg.sv
// Types shared by the datapath configuration block
`include "datapath_params.svh"
package datapath_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_INSTR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_DONE = 4'b1000
	} spi_state_e;

	typedef enum logic [1:0] {
		INTERP_X1 = 2'b00,
		INTERP_X2 = 2'b01,
		INTERP_X4 = 2'b10,
		INTERP_X8 = 2'b11
	} interp_e;

	typedef struct packed {
		logic [`DP_SAMPLE_W-1:0] i;
		logic [`DP_SAMPLE_W-1:0] q;
	} sample_pair_s;

endpackage : datapath_pkg

// File: hw/sync2.sv
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule : sync2

// File: sim/dp_asserts.sv
// Port assertions for the datapath configuration block
`timescale 1ns/100ps
`include "datapath_params.svh"
module dp_asserts import datapath_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic SPI_CS_N,
	input wire logic SPI_SDO_OE,
	input wire logic [`DP_SAMPLE_W-1:0] FIRST_DATA_PORT,
	input wire logic [`DP_SAMPLE_W-1:0] SECOND_DATA_PORT,
	input wire logic DATA_CLOCK_OUT_PIN,
	input wire logic DATA_CLOCK_OUT_OE,
	input wire sample_pair_s SAMPLE_PAIR,
	input wire logic SAMPLE_VALID,
	input wire interp_e INTERP_FACTOR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence idle; SPI_CS_N [*4]; endsequence
	sequence run3; SAMPLE_VALID [*3]; endsequence
	AST_CFG_HOLD: assert property (
		idle |=> $stable({DATA_CLOCK_OUT_OE, INTERP_FACTOR}))
		else $error("config moved while idle");
	AST_SDO_QUIET: assert property (idle |-> !SPI_SDO_OE)
		else $error("read data driven while idle");
	AST_DCLK_OFF: assert property (
		!DATA_CLOCK_OUT_OE && !$past(DATA_CLOCK_OUT_OE) |-> !DATA_CLOCK_OUT_PIN)
		else $error("data clock active while off");
	AST_DCLK_RUN: assert property (
		DATA_CLOCK_OUT_OE && $past(DATA_CLOCK_OUT_OE) && !$past(RST) |->
		DATA_CLOCK_OUT_PIN != $past(DATA_CLOCK_OUT_PIN))
		else $error("data clock stuck");
	AST_DCLK_START: assert property (
		$rose(DATA_CLOCK_OUT_OE) |=> DATA_CLOCK_OUT_PIN)
		else $error("data clock did not start");
	AST_PAIR_HOLD: assert property (
		!SAMPLE_VALID |-> $stable(SAMPLE_PAIR))
		else $error("pair moved without valid");
	AST_DUAL_I: assert property (run3 |->
		$past(SAMPLE_PAIR.i[14:0]) == $past(FIRST_DATA_PORT[14:0], 4))
		else $error("dual port I word wrong");
	AST_DUAL_Q: assert property (run3 |->
		$past(SAMPLE_PAIR.q[14:0]) == 15'h0000 ||
		$past(SAMPLE_PAIR.q[14:0]) == $past(SECOND_DATA_PORT[14:0], 4))
		else $error("dual port Q word wrong");
endmodule : dp_asserts
bind datapath_config_top dp_asserts dp_asserts_inst (
	.REF_CLK(REF_CLK), .RST(RST), .SPI_CS_N(SPI_CS_N),
	.SPI_SDO_OE(SPI_SDO_OE), .FIRST_DATA_PORT(FIRST_DATA_PORT),
	.SECOND_DATA_PORT(SECOND_DATA_PORT),
	.DATA_CLOCK_OUT_PIN(DATA_CLOCK_OUT_PIN),
	.DATA_CLOCK_OUT_OE(DATA_CLOCK_OUT_OE), .SAMPLE_PAIR(SAMPLE_PAIR),
	.SAMPLE_VALID(SAMPLE_VALID), .INTERP_FACTOR(INTERP_FACTOR));

// File: sim/datapath_control_register_tb_top.sv
// Self-checking bench for the datapath configuration block
`timescale 1ns/100ps
module datapath_control_register_tb_top import datapath_pkg::*;;
	logic clk = 0, rst = 1, cs_n = 1, sck = 0, sdi = 0, gt = 0;
	logic sdo, oe, dk, dko, vld, phc, pne, spn, pse, isc, hg;
	logic [15:0] p1 = 0, p2 = 0, m = 16'h0100, rn = 16'h001E;
	logic [32:0] eq [$];
	logic [15:0] cf [6] = '{16'h0000, 16'h0028, 16'h0010,
		16'h0012, 16'h0034, 16'h003E};
	sample_pair_s pr;
	interp_e ifa;
	int n_mismatch = 0, compares = 0, cyc = 0;
	wire logic [8:0] cfo = {phc, pne, spn, pse, isc, dko, ifa, hg};
	wire logic [8:0] mo = {m[14:11], m[9:6], m[0]};
	always #12.5 clk = ~clk;
	datapath_config_top datapath_config_top_inst (
		.REF_CLK(clk), .RST(rst), .SPI_CS_N(cs_n), .SPI_SCLK(sck),
		.SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(oe),
		.FIRST_DATA_PORT(p1), .SECOND_DATA_PORT(p2),
		.TRANSMIT_GATE_PIN(gt), .DATA_CLOCK_OUT_PIN(dk),
		.DATA_CLOCK_OUT_OE(dko), .SAMPLE_PAIR(pr), .SAMPLE_VALID(vld),
		.NCO_PHASE_CLEAR(phc), .PN_SYNC_ENABLE(pne), .SYNC_MODE_PN(spn),
		.PULSE_SYNC_ENABLE(pse), .INV_SINC_ENABLE(isc),
		.INTERP_FACTOR(ifa), .NCO_HALF_GAIN(hg));
	task results;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	function automatic logic [15:0] xs();
		rn ^= rn << 7;
		rn ^= rn >> 9;
		rn ^= rn << 8;
		return rn;
	endfunction : xs
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	// Gate keeps alternating so single-port words never repeat a kind
	task tk(input int k);
		repeat (k) begin
			@(negedge clk);
			gt = ~gt;
		end
	endtask : tk
	// Mode 0 frame, each clock phase six reference cycles
	task spi(input logic [23:0] w, output logic [15:0] r);
		r = 0;
		cs_n = 0;
		tk(3);
		for (int b = 23; b >= 0; b--) begin
			sdi = w[b];
			tk(6);
			r = {r[14:0], sdo};
			sck = 1;
			tk(6);
			sck = 0;
		end
		tk(6);
		cs_n = 1;
		tk(8);
	endtask : spi
	task wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] r;
		spi({3'h0, a, d}, r);
		if (a == 5'h01) m = d & 16'h7BFF;
		spi({3'h4, a, 16'h0000}, r);
		chk(32'(r), 32'(a == 5'h01 ? m : 16'h0000));
		chk(32'(cfo), 32'(mo));
	endtask : wr
	// Streams sixteen words and predicts each assembled pair
	task pass(input logic [15:0] c);
		logic i;
		logic [15:0] s, x, hi, hq;
		logic [32:0] e;
		wr(5'h01, c);
		s = {c[5], 15'h0000};
		eq.delete();
		for (int n = 0; n < 16; n++) begin
			@(negedge clk);
			if (n > 2) begin
				e = eq.pop_front();
				chk(32'(vld), 32'(e[32]));
				if (e[32]) chk(pr, e[31:0]);
			end
			p1 = xs();
			p2 = xs();
			i = ~n[0] ^ c[1];
			gt = i ^ c[2];
			x = p1 ^ s;
			e = {!c[4], x, c[3] ? 16'h0000 : p2 ^ s};
			if (c[4]) begin
				if (i) hi = x;
				else hq = c[3] ? 16'h0000 : x;
				e = {i == c[1], hi, hq};
			end
			eq.push_back(e);
		end
	endtask : pass
	always @(posedge clk) begin
		cyc++;
		if (cyc == 25000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		tk(3);
		rst = 0;
		tk(4);
		wr(5'h1F, xs());
		repeat (6) wr(5'h01, xs());
		for (int j = 0; j < 4; j++) wr(5'h01, 16'(j << 6));
		wr(5'h01, 16'hFFFF);
		foreach (cf[j]) pass(cf[j]);
		results();
	end
endmodule : datapath_control_register_tb_top
